// File: hdl/rss_reset_source_sequencer.sv
// Purpose: merge reset sources, run start-up timers, keep cause flags
// Assumes: all inputs synchronous to aclk; aresetn is the power-on reset
// Notes: flags update on the first cycle of each reset event that stops a running core
// Functional notes
// - mode 01: software bit enables brown-out
// - soft mode skips readiness only when disabled
// - protection starts at ready, ready bit readable
// - mode 00: brown-out off, software bit ignored
// - low-power trip holds reset, clears flag
// - combined brown-out is OR of both trips
// - mode 10 trip holds reset, re-arms power-on
// - low-power trip enabled only by config bit
// - pin reset enabled by program or pin bit
// - low pin holds reset, short pulses filtered
// - pin never driven low by reset
// - disabled pin is input, software pull-up
// - watchdog timeout resets, clears flags
// - reset instruction resets, clears its flag
// - stack faults reset when enabled, set flags
// - programming exit behaves as device reset
// - power-up timer holds reset 64 ms
// - run after timer, pin, oscillator done
// - timers ignore pin; run 10 cycles after
// - power-on and pin reset flag values
// - brown-out reset flag values
// - wake from sleep status bit values
module rss_reset_source_sequencer
   import rss_pkg::*;
#(
   parameter int unsigned PUT_CYCLES = PUT_CYC
)
(
   // clock and power-on reset
   input wire logic aclk,
   input wire logic aresetn,
   // configuration words
   input wire logic [1:0] brownout_mode_cfg,
   input wire logic lowpower_trip_cfg_en,
   input wire logic ext_reset_pin_enable,
   input wire logic lowvolt_program_cfg,
   input wire logic stack_reset_enable,
   input wire logic powerup_timer_enable_n,
   input wire logic osc_needs_ost,
   // analog detectors
   input wire logic bor_trip,
   input wire logic brownout_ready,
   input wire logic lowpower_supply_trip,
   // external pin and its pull-up
   input wire logic ext_reset_pin_n,
   input wire logic sw_pullup_en,
   output logic pin_pullup_en,
   output logic pin_gpio_in,
   output logic pin_oe,
   output logic pin_out,
   // core events
   input wire logic wdt_timeout,
   input wire logic reset_instr,
   input wire logic stack_over,
   input wire logic stack_under,
   input wire logic prog_exit,
   input wire logic sleeping,
   input wire logic wdt_wake,
   input wire logic irq_wake,
   input wire logic ost_done,
   // core reset and detector enable
   output logic core_reset,
   output logic bor_enable,
   // axi4-lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   // start-up sequence
   rss_state_t st_q, st_d;
   logic [31:0] cnt_q, cnt_d;       // power-up and run delay counter
   logic [2:0] filt_q, filt_d;      // pin low filter counter
   logic pin_low_q, pin_low_d;      // filtered pin-low level
   logic pwr_q, pwr_d;              // a power-on/brown-out start pending
   // software registers and flags
   logic soft_en_q, soft_en_d;
   logic [7:0] cause_q, cause_d;
   logic [1:0] status_q, status_d;
   logic rst_q, rst_d;              // previous core reset level
   logic por_q, por_d;              // first cycle after aresetn release
   // axi write channel state
   logic aw_q, aw_d;
   logic [7:0] awa_q, awa_d;
   logic w_q, w_d;
   logic [31:0] wd_q, wd_d;
   logic [3:0] ws_q, ws_d;
   logic bv_q, bv_d;
   logic [1:0] br_q, br_d;
   // axi read channel state
   logic rv_q, rv_d;
   logic [31:0] rd_q, rd_d;
   logic [1:0] rr_q, rr_d;

   // combinational source terms
   logic pin_rst_en, bor_on, bor_evt, lp_evt, gbor, pin_rst, evt_rst;
   logic any_rst, do_wr, wake;

   // decode a register offset; returns 1 when mapped
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_BORCTL) || (a == OFS_CAUSE) || (a == OFS_STATUS);
   endfunction

   // source enables and merge
   always_comb
   begin
      pin_rst_en = lowvolt_program_cfg | ext_reset_pin_enable;
      // brown-out enable per mode
      if (brownout_mode_cfg == BORM_OFF)
      begin
         bor_on = 1'b0;
      end
      else if (brownout_mode_cfg == BORM_SOFT)
      begin
         bor_on = soft_en_q;
      end
      else if (brownout_mode_cfg == BORM_NOSLEEP)
      begin
         bor_on = ~sleeping;
      end
      else
      begin
         bor_on = 1'b1;
      end
      // protection acts only once the circuit is ready
      bor_evt = bor_on & brownout_ready & bor_trip;
      lp_evt = lowpower_trip_cfg_en & lowpower_supply_trip;
      gbor = bor_evt | lp_evt;
      pin_rst = pin_rst_en & pin_low_q;
      evt_rst = wdt_timeout | reset_instr | prog_exit
         | (stack_reset_enable & (stack_over | stack_under));
      any_rst = gbor | pin_rst | evt_rst;
      wake = sleeping & (wdt_wake | irq_wake);
   end

   // pin: never driven, pull-up follows mode
   always_comb
   begin
      pin_oe = 1'b0;
      pin_out = 1'b0;
      pin_pullup_en = pin_rst_en ? 1'b1 : sw_pullup_en;
      pin_gpio_in = pin_rst_en ? 1'b1 : ext_reset_pin_n;
      bor_enable = bor_on;
      core_reset = (st_q != RSS_RUN) | any_rst;
   end

   // pin filter and start-up sequence next state
   always_comb
   begin
      filt_d = filt_q;
      pin_low_d = pin_low_q;
      st_d = st_q;
      cnt_d = cnt_q;
      pwr_d = pwr_q;
      // pin must stay low for the filter length to count
      if (ext_reset_pin_n)
      begin
         filt_d = 3'h0;
         pin_low_d = 1'b0;
      end
      else if (32'(filt_q) + 32'h1 >= PIN_FILT_CYC)
      begin
         pin_low_d = 1'b1;
      end
      else
      begin
         filt_d = filt_q + 3'h1;
      end
      // brown-out re-arms power-up sequencing
      if (gbor | (~por_q & ~aresetn))
      begin
         pwr_d = 1'b1;
      end
      case (st_q)
         RSS_HOLD:
         begin
            // wait for brown-out release; soft-off skips readiness
            cnt_d = 32'h0;
            if (!gbor && (!bor_on || brownout_ready))
            begin
               st_d = (pwr_q && !powerup_timer_enable_n) ? RSS_PUT
                  : RSS_WAIT;
            end
         end
         RSS_PUT:
         begin
            // power-up timer runs regardless of the pin
            if (cnt_q + 32'h1 >= PUT_CYCLES)
            begin
               cnt_d = 32'h0;
               st_d = RSS_WAIT;
            end
            else
            begin
               cnt_d = cnt_q + 32'h1;
            end
         end
         RSS_WAIT:
         begin
            // pin released and oscillator ready, then 10 cycles
            if (pin_rst || (osc_needs_ost && !ost_done))
            begin
               cnt_d = 32'h0;
            end
            else if (cnt_q + 32'h1 >= PIN_RUN_CYC)
            begin
               st_d = RSS_RUN;
               pwr_d = 1'b0;
            end
            else
            begin
               cnt_d = cnt_q + 32'h1;
            end
         end
         default:
         begin
            cnt_d = 32'h0;
         end
      endcase
      // any source drops back to hold; a low pin stops only a running
      // core, so the start-up timers keep counting through it
      if (gbor || evt_rst || (pin_rst && st_q == RSS_RUN))
      begin
         st_d = RSS_HOLD;
      end
   end

   // sequencer registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= RSS_HOLD;
         cnt_q <= 32'h0;
         filt_q <= 3'h0;
         pin_low_q <= 1'b0;
         pwr_q <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         filt_q <= filt_d;
         pin_low_q <= pin_low_d;
         pwr_q <= pwr_d;
      end
   end

   // cause flags, status bits, software writes
   always_comb
   begin
      do_wr = aw_q & w_q & ~bv_q & mapped(awa_q);
      soft_en_d = soft_en_q;
      cause_d = cause_q;
      status_d = status_q;
      rst_d = core_reset;
      por_d = 1'b1;
      // software writes first; hardware events below override them
      if (do_wr && ws_q[0])
      begin
         if (awa_q == OFS_BORCTL)
         begin
            soft_en_d = wd_q[BIT_SOFT_EN];
         end
         else if (awa_q == OFS_CAUSE)
         begin
            cause_d = wd_q[7:0] & 8'hdf;
         end
         else if (awa_q == OFS_STATUS)
         begin
            status_d = wd_q[1:0];
         end
      end
      // cause flags change only on the first cycle of a reset event; status bits also on wake
      if (any_rst && !rst_q)
      begin
         if (gbor)
         begin
            cause_d[BIT_BOR] = 1'b0;
            cause_d[BIT_SOVER] = 1'b0;
            cause_d[BIT_SUNDER] = 1'b0;
            cause_d[BIT_PIN] = 1'b1;
            cause_d[BIT_INSTR] = 1'b1;
            status_d = STATUS_POR_VAL;
         end
         else
         begin
            if (pin_rst)
            begin
               cause_d[BIT_PIN] = 1'b0;
               if (sleeping)
               begin
                  status_d = 2'h2;
               end
            end
            if (wdt_timeout)
            begin
               cause_d[BIT_WDT] = 1'b0;
               status_d[BIT_TO] = 1'b0;
            end
            if (reset_instr)
            begin
               cause_d[BIT_INSTR] = 1'b0;
            end
            if (stack_reset_enable && stack_over)
            begin
               cause_d[BIT_SOVER] = 1'b1;
            end
            if (stack_reset_enable && stack_under)
            begin
               cause_d[BIT_SUNDER] = 1'b1;
            end
         end
      end
      else if (wake)
      begin
         status_d[BIT_PDOWN] = 1'b0;
         status_d[BIT_TO] = ~wdt_wake;
      end
   end

   // flag registers; power-on reset loads flag defaults
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         soft_en_q <= SOFT_EN_RST;
         cause_q <= CAUSE_POR_VAL;
         status_q <= STATUS_POR_VAL;
         rst_q <= 1'b1;
         por_q <= 1'b0;
      end
      else
      begin
         soft_en_q <= soft_en_d;
         cause_q <= cause_d;
         status_q <= status_d;
         rst_q <= rst_d;
         por_q <= por_d;
      end
   end

   // axi4-lite channel logic
   always_comb
   begin
      aw_d = aw_q;
      awa_d = awa_q;
      w_d = w_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      s_awready = ~aw_q & ~bv_q;
      s_wready = ~w_q & ~bv_q;
      s_arready = ~rv_q;
      // capture address and data in either order
      if (s_awvalid && s_awready)
      begin
         aw_d = 1'b1;
         awa_d = s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
         w_d = 1'b1;
         wd_d = s_wdata;
         ws_d = s_wstrb;
      end
      // both held: answer
      if (aw_q && w_q && !bv_q)
      begin
         bv_d = 1'b1;
         br_d = mapped(awa_q) ? RESP_OKAY : RESP_SLVERR;
         aw_d = 1'b0;
         w_d = 1'b0;
      end
      else if (bv_q && s_bready)
      begin
         bv_d = 1'b0;
      end
      // read: decode and register the data
      if (s_arvalid && s_arready)
      begin
         rv_d = 1'b1;
         rr_d = RESP_OKAY;
         if (s_araddr == OFS_BORCTL)
         begin
            rd_d = {24'h0, soft_en_q, 6'h0, brownout_ready};
         end
         else if (s_araddr == OFS_CAUSE)
         begin
            rd_d = {24'h0, cause_q};
         end
         else if (s_araddr == OFS_STATUS)
         begin
            rd_d = {30'h0, status_q};
         end
         else
         begin
            rd_d = 32'h0;
            rr_d = RESP_SLVERR;
         end
      end
      else if (rv_q && s_rready)
      begin
         rv_d = 1'b0;
      end
      s_bvalid = bv_q;
      s_bresp = br_q;
      s_rvalid = rv_q;
      s_rdata = rd_q;
      s_rresp = rr_q;
   end

   // axi registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_q <= 1'b0;
         awa_q <= 8'h00;
         w_q <= 1'b0;
         wd_q <= 32'h0;
         ws_q <= 4'h0;
         bv_q <= 1'b0;
         br_q <= 2'h0;
         rv_q <= 1'b0;
         rd_q <= 32'h0;
         rr_q <= 2'h0;
      end
      else
      begin
         aw_q <= aw_d;
         awa_q <= awa_d;
         w_q <= w_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
      end
   end
endmodule

// File: inc/rss_pkg.sv
// Purpose: constants and types for the reset source sequencer
// Assumes: 10 MHz system clock, AXI4-Lite register access
// Notes: offsets are byte addresses of 32-bit words
package rss_pkg;
   // clock rate
   localparam int unsigned CLK_HZ = 10_000_000;
   // power-up timer nominal time
   localparam int unsigned PUT_MS = 64;
   localparam int unsigned PUT_CYC = (PUT_MS * (CLK_HZ / 1000));
   // delay from pin release to run, in oscillator cycles
   localparam int unsigned PIN_RUN_CYC = 10;
   // pin glitch filter length in cycles
   localparam int unsigned PIN_FILT_CYC = 4;
   // register byte offsets
   localparam logic [7:0] OFS_BORCTL = 8'h00;
   localparam logic [7:0] OFS_CAUSE = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   // brown-out control field positions
   localparam int BIT_SOFT_EN = 7;
   localparam int BIT_READY = 0;
   // cause register field positions
   localparam int BIT_SOVER = 7;
   localparam int BIT_SUNDER = 6;
   localparam int BIT_WDT = 4;
   localparam int BIT_PIN = 3;
   localparam int BIT_INSTR = 2;
   localparam int BIT_POR = 1;
   localparam int BIT_BOR = 0;
   // status register field positions
   localparam int BIT_TO = 1;
   localparam int BIT_PDOWN = 0;
   // reset values
   localparam logic SOFT_EN_RST = 1'b1;
   localparam logic [7:0] CAUSE_POR_VAL = 8'h1c;
   localparam logic [1:0] STATUS_POR_VAL = 2'h3;
   // brown-out mode encodings
   localparam logic [1:0] BORM_OFF = 2'h0;
   localparam logic [1:0] BORM_SOFT = 2'h1;
   localparam logic [1:0] BORM_NOSLEEP = 2'h2;
   localparam logic [1:0] BORM_ON = 2'h3;
   // axi answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // start-up sequence states
   typedef enum logic [1:0] {RSS_HOLD, RSS_PUT, RSS_WAIT, RSS_RUN} rss_state_t;
endpackage

// File: sim/rss_chk_assertions.sv
// Purpose: port-level checks for the reset source sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to every instance of the sequencer
module rss_chk
   import rss_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // configuration and sources
   input wire logic [1:0] brownout_mode_cfg,
   input wire logic lowpower_trip_cfg_en,
   input wire logic ext_reset_pin_enable,
   input wire logic lowvolt_program_cfg,
   input wire logic stack_reset_enable,
   input wire logic lowpower_supply_trip,
   input wire logic ext_reset_pin_n,
   input wire logic sw_pullup_en,
   input wire logic wdt_timeout,
   input wire logic reset_instr,
   input wire logic stack_over,
   input wire logic stack_under,
   input wire logic prog_exit,
   // watched outputs
   input wire logic pin_pullup_en,
   input wire logic pin_gpio_in,
   input wire logic pin_oe,
   input wire logic pin_out,
   input wire logic core_reset,
   input wire logic bor_enable,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic s_rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // pin reset function is on when either config bit is set
   wire logic pin_en = ext_reset_pin_enable | lowvolt_program_cfg;
   a_pin_never_driven:
      assert property (!pin_oe && !pin_out) else $error("pin driven");
   a_pin_low_holds:
      assert property ((pin_en && !ext_reset_pin_n)[*6] |-> core_reset)
      else $error("low pin did not hold reset");
   a_pin_gpio_use:
      assert property (!pin_en |-> pin_pullup_en == sw_pullup_en
         && pin_gpio_in == ext_reset_pin_n) else $error("gpio pin wrong");
   a_event_reset:
      assert property (wdt_timeout || reset_instr || prog_exit
         |-> core_reset) else $error("core event without reset");
   a_stack_reset:
      assert property (stack_reset_enable && (stack_over || stack_under)
         |-> core_reset) else $error("stack fault without reset");
   a_lp_trip_reset:
      assert property (lowpower_trip_cfg_en && lowpower_supply_trip
         |-> core_reset) else $error("low-power trip without reset");
   a_bor_mode_off:
      assert property (brownout_mode_cfg == BORM_OFF |-> !bor_enable)
      else $error("brown-out on in off mode");
   a_read_answer_next:
      assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
endmodule

bind rss_reset_source_sequencer rss_chk chk (.*);

// File: sim/rss_core_model.sv
// Purpose: far-side model: oscillator start-up and detector readiness
// Assumes: oscillator count restarts at power-on reset, readiness count whenever the detector is off
// Notes: counts are parameters so prompt and slow parts can be modelled
module rss_core_model #(
   parameter int OST_CYC = 5,
   parameter int RDY_CYC = 3
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // detector enable from the sequencer
   input wire logic bor_enable,
   // model answers
   output logic ost_done,
   output logic brownout_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   int ost_n = 0;
   int rdy_n = 0;
   // readiness only after the detector has been on for a while
   always @(posedge aclk)
   begin
      ost_n <= !aresetn ? 0 : (ost_n < OST_CYC ? ost_n + 1 : ost_n);
      rdy_n <= !bor_enable ? 0 : (rdy_n < RDY_CYC ? rdy_n + 1 : rdy_n);
   end
   assign ost_done = ost_n >= OST_CYC;
   assign brownout_ready = rdy_n >= RDY_CYC;
endmodule

// File: sim/tb_top.sv
// Purpose: self-checking bench for the reset source sequencer
// Assumes: 10 MHz clock, bench is the AXI4-Lite master
// Notes: power-up count shortened to PW cycles
module tb_top;
   import rss_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PW = 20;
   // config, detectors, pin, core events
   logic aclk = 0, aresetn = 0, lpen = 0, pinen = 1, lowv = 0, stken = 1;
   logic pwrtn = 0, bort = 0, lpt = 0, pin_n = 1, swpu = 0, slp = 0;
   logic wwk = 0, iwk = 0, ostr = 1;
   logic [1:0] bmode = BORM_ON;
   logic [4:0] ev = '0; // wdt, instr, over, under, prog exit
   // bus master side
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdat, rdata, d, e;
   logic [3:0] wstrb = '0, st;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [1:0] resp, bresp, rresp;
   // design and model outputs
   logic pu, gi, core_reset, bor_en, ost, rdy;
   logic awready, wready, bvalid, arready, rvalid;
   int n_fail = 0, comparisons = 0, cyc;
   int src[5] = '{0, 1, 2, 3, 5};
   rss_reset_source_sequencer #(.PUT_CYCLES(PW)) dut (
      .aclk(aclk), .aresetn(aresetn), .brownout_mode_cfg(bmode),
      .lowpower_trip_cfg_en(lpen), .ext_reset_pin_enable(pinen),
      .lowvolt_program_cfg(lowv), .stack_reset_enable(stken),
      .powerup_timer_enable_n(pwrtn), .osc_needs_ost(ostr),
      .bor_trip(bort), .brownout_ready(rdy), .lowpower_supply_trip(lpt),
      .ext_reset_pin_n(pin_n), .sw_pullup_en(swpu), .pin_pullup_en(pu),
      .pin_gpio_in(gi), .pin_oe(), .pin_out(), .wdt_timeout(ev[0]),
      .reset_instr(ev[1]), .stack_over(ev[2]), .stack_under(ev[3]),
      .prog_exit(ev[4]), .sleeping(slp), .wdt_wake(wwk), .irq_wake(iwk),
      .ost_done(ost), .core_reset(core_reset), .bor_enable(bor_en),
      .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
      .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
      .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
      .s_rvalid(rvalid), .s_rready(rready));
   rss_core_model model (.aclk(aclk), .aresetn(aresetn),
      .bor_enable(bor_en), .ost_done(ost), .brownout_ready(rdy));
   // 100 ns clock
   initial
   begin
      forever #50 aclk = ~aclk;
   end
   task tk(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] x);
      comparisons++;
      if (got !== x)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, x, got);
      end
   endtask
   task conclude;
      $display("compared %0d, mismatched %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // write: address and data offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] v,
           input logic [3:0] s = 4'h1);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (rvalid !== 1'b1);
      resp = rresp;
      rdat = rdata;
      rready <= 0;
   endtask
   task rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
      rd(a);
      chk(nm, rdat, x);
   endtask
   // wait for the core to run, counting cycles
   task wrun;
      cyc = 0;
      while (core_reset !== 1'b0 && cyc < 3000)
      begin
         @(posedge aclk);
         cyc++;
      end
      chk("core run", core_reset, 0);
   endtask
   // 5 pin, 6 main brown-out trip, 7 low-power trip, else core event
   task drv(input int i, input logic v);
      case (i)
         5: pin_n <= !v;
         6: bort <= v;
         7: lpt <= v;
         default: ev[i] <= v;
      endcase
   endtask
   function logic [7:0] exp_cause(input int i, input logic [7:0] c);
      case (i)
         0: c[BIT_WDT] = 0;
         1: c[BIT_INSTR] = 0;
         2: c[BIT_SOVER] = 1;
         3: c[BIT_SUNDER] = 1;
         5: c[BIT_PIN] = 0;
         default: c = {2'h0, c[5:4], 2'h3, c[1], 1'b0};
      endcase
      return c;
   endfunction
   function logic [1:0] exp_stat(input int i, input logic [1:0] s);
      if (i == 0) s[BIT_TO] = 0;
      if (i >= 6) s = 2'h3;
      return s;
   endfunction
   // source fired from random flag states, then flags compared
   task fire(input int i);
      logic [7:0] c;
      logic [1:0] s;
      c = 8'($urandom) & 8'hdf;
      s = 2'($urandom);
      wr(OFS_CAUSE, c);
      wr(OFS_STATUS, s);
      drv(i, 1);
      tk(6);
      drv(i, 0);
      wrun();
      if (i >= 6) chk("bor put", cyc >= PW, 1);
      rchk("cause", OFS_CAUSE, exp_cause(i, c));
      rchk("status", OFS_STATUS, exp_stat(i, s));
   endtask
   // source that must be ignored
   task quiet(input int i, input string nm);
      drv(i, 1);
      tk(6);
      chk(nm, core_reset, 0);
      drv(i, 0);
      tk(1);
   endtask
   initial
   begin
      tk(30000);
      n_fail++;
      $display("watchdog expired");
      conclude();
   end
   initial
   begin
      void'($urandom(71));
      tk(8);
      aresetn <= 1;
      wrun();
      chk("put", cyc >= PW + PIN_RUN_CYC, 1);
      rchk("por cause", OFS_CAUSE, CAUSE_POR_VAL);
      rchk("por status", OFS_STATUS, STATUS_POR_VAL);
      rchk("ctrl", OFS_BORCTL, 32'h81);
      $display("done: power-on");
      pin_n <= 0;
      aresetn <= 0;
      tk(2);
      aresetn <= 1;
      tk(PW + 40);
      chk("pin hold", core_reset, 1);
      pin_n <= 1;
      wrun();
      chk("pin run", cyc >= PIN_RUN_CYC && cyc <= PIN_RUN_CYC + 6, 1);
      pwrtn <= 1;
      aresetn <= 0;
      tk(2);
      aresetn <= 1;
      wrun();
      chk("no put", cyc < PW + PIN_RUN_CYC, 1);
      ostr <= 0;
      aresetn <= 0;
      tk(2);
      aresetn <= 1;
      wrun();
      chk("no ost", cyc <= PIN_RUN_CYC + 3, 1);
      ostr <= 1;
      pwrtn <= 0;
      $display("done: start-up");
      foreach (src[k]) fire(src[k]);
      ev[4] <= 1;
      tk(3);
      chk("prog exit", core_reset, 1);
      ev[4] <= 0;
      wrun();
      stken <= 0;
      quiet(2, "stack off");
      stken <= 1;
      $display("done: sources");
      bmode <= BORM_OFF;
      tk(4);
      chk("bor off", bor_en, 0);
      quiet(6, "bor off trip");
      bmode <= BORM_SOFT;
      wr(OFS_BORCTL, 0);
      tk(4);
      chk("soft off", bor_en, 0);
      quiet(6, "soft off trip");
      wr(OFS_BORCTL, 32'h80);
      tk(8);
      rchk("soft ready", OFS_BORCTL, 32'h81);
      fire(6);
      quiet(7, "lp off");
      lpen <= 1;
      fire(7);
      bmode <= BORM_NOSLEEP;
      fire(7);
      lpen <= 0;
      bmode <= BORM_ON;
      $display("done: brown-out");
      for (int k = 0; k < 2; k++)
      begin
         wr(OFS_STATUS, 32'h3);
         slp <= 1;
         tk(2);
         wwk <= (k == 0);
         iwk <= (k == 1);
         tk(1);
         wwk <= 0;
         iwk <= 0;
         slp <= 0;
         rchk("wake", OFS_STATUS, k == 1 ? 32'h2 : 32'h0);
      end
      pinen <= 0;
      swpu <= 0;
      quiet(5, "pin off");
      chk("pullup", pu, 0);
      lowv <= 1;
      fire(5);
      lowv <= 0;
      pinen <= 1;
      swpu <= 0;
      $display("done: sleep and pin");
      wr(OFS_CAUSE, 0);
      tk(4);
      chk("write no reset", core_reset, 0);
      e = 0;
      for (int k = 0; k < 6; k++)
      begin
         d = $urandom;
         st = (k == 0) ? 4'he : 4'($urandom);
         wr(OFS_CAUSE, d, st);
         chk("bresp", resp, RESP_OKAY);
         if (st[0]) e = d & 32'hdf;
         rchk("cause rw", OFS_CAUSE, e);
      end
      wr(8'h0c, 32'hffff_ffff);
      chk("wr unmapped", resp, RESP_SLVERR);
      rchk("rd unmapped", 8'h0c, 0);
      chk("rd resp", resp, RESP_SLVERR);
      $display("done: register bus");
      conclude();
   end
endmodule
